// >>> hdl/pths_top.sv
// Package thermal alarm: per-core sensing, hot pin, staged throttling, trip
// Assumes readings arrive on mclk; the hot pin is asynchronous and wired-low
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "pths_regs.svh"
module pths_top #(
    parameter int NUM_CORES = 4,
    parameter int SAMPLE_CYC = `PTHS_AVG_SAMPLE_CYC,
    parameter int STEP_CYC = `PTHS_STEP_CYC,
    parameter logic [3:0] MAX_PERF = 4'hf,
    parameter logic [7:0] MAX_TEMP = `PTHS_MAX_TEMP_DEF,
    parameter logic [7:0] TRIP_MARGIN = `PTHS_TRIP_MARGIN_DEF
) (
    // Clocking
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire pths_pkg::pths_word_t wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output pths_pkg::pths_word_t rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Core sensors, absolute codes
    input wire logic [NUM_CORES*8-1:0] coreTempSensor,
    input wire logic pkgDeepIdle,
    // Package hot pin, open drain
    input wire logic packageHotPinIn_n,
    output logic packageHotPinOut_n,
    output logic packageHotPinOe,
    // Throttling and alarms
    output logic [3:0] perfLevel,
    output logic clkModEn,
    output logic thermCtlActive,
    output logic [2*NUM_CORES-1:0] coreThreshIrq,
    output logic hotEdgeIrq,
    output logic catastrophicTripOut_n,
    output logic shutdownReq
);
    import pths_pkg::*;

    if (NUM_CORES < 1 || NUM_CORES > 8)
        $error("NUM_CORES must be 1 to 8");
    if (SAMPLE_CYC < 1 || SAMPLE_CYC >= (1 << `PTHS_CNT_W))
        $error("SAMPLE_CYC out of counter range");
    if (STEP_CYC < 1 || STEP_CYC >= (1 << `PTHS_CNT_W))
        $error("STEP_CYC out of counter range");
    if (`PTHS_HOT_PIPE_CYC > `PTHS_HOT_RESP_CYC)
        $error("Hot pin response path too slow");

    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
    localparam pths_cnt_t SAMPLE_LAST = pths_cnt_t'(SAMPLE_CYC - 1);
    localparam pths_cnt_t STEP_LAST = pths_cnt_t'(STEP_CYC - 1);

    function automatic pths_temp_t toRelative(input pths_temp_t absT);
        return (absT >= MAX_TEMP) ? 8'h00 : pths_temp_t'(MAX_TEMP - absT);
    endfunction

    function automatic pths_word_t mergeStrb(input pths_word_t old, input pths_word_t nw,
                                             input logic [3:0] strb);
        pths_word_t res;
        res = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                res[b*8 +: 8] = nw[b*8 +: 8];
        return res;
    endfunction

    // Per-core slot decode; returns NUM_CORES when not a slot of that bank
    function automatic int coreSlot(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] d;
        d = addr - base;
        if (addr >= base && d[1:0] == 2'b00 && int'(d[7:2]) < NUM_CORES)
            return int'(d[7:2]);
        return NUM_CORES;
    endfunction

    // Register state
    logic [`PTHS_REF_OFS_W-1:0] actOffset;
    pths_word_t ctrl;
    pths_word_t thresh [NUM_CORES];
    logic extAssertSeen;
    logic extReleaseSeen;
    // Sensing state
    pths_temp_t relNow [NUM_CORES];
    pths_temp_t relPrev [NUM_CORES];
    logic [NUM_CORES-1:0] coreAtAct;
    logic [NUM_CORES-1:0] coreTrip;
    pths_temp_t hottest;
    logic anyAct;
    logic anyTrip;
    // AXI holding state
    logic [7:0] awAddrQ;
    pths_word_t wDataQ;
    logic [3:0] wStrbQ;
    logic awHeld;
    logic wHeld;
    logic writeFire;
    // Hot pin state
    logic hotSyncA;
    logic hotSyncB;
    logic oeD1;
    logic oeD2;
    logic extHot;
    logic extHotNow;
    logic next_drive;
    pths_perf_t perfState;
    pths_cnt_t stepCnt;
    pths_cnt_t sampleCnt;
    logic tripped;

    pths_avg_if avgLink ();

    assign writeFire = awHeld && wHeld && !bvalid;

    // Per-core relative reading, saturated at the maximum
    for (genvar c = 0; c < NUM_CORES; c++)
    begin : g_core
        pths_temp_t absT;
        assign absT = coreTempSensor[c*8 +: 8];
        assign coreAtAct[c] = relNow[c] <= {2'b00, actOffset};
        assign coreTrip[c] = {1'b0, absT} >= ({1'b0, MAX_TEMP} + {1'b0, TRIP_MARGIN});

        always_ff @(posedge mclk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                relNow[c] <= 8'hff;
                relPrev[c] <= 8'hff;
            end
            else if (ce)
            begin
                relNow[c] <= toRelative(absT);
                relPrev[c] <= relNow[c];
            end
        end

        // A crossing of an enabled threshold in either direction pulses that threshold's own interrupt line
        always_ff @(posedge mclk or negedge rst_n)
        begin
            if (!rst_n)
                coreThreshIrq[2*c +: 2] <= 2'b00;
            else if (ce)
            begin
                coreThreshIrq[2*c] <= thresh[c][`PTHS_THR0_EN] &&
                    ((relNow[c] > thresh[c][`PTHS_THR0_LSB +: 8]) !=
                     (relPrev[c] > thresh[c][`PTHS_THR0_LSB +: 8]));
                coreThreshIrq[2*c+1] <= thresh[c][`PTHS_THR1_EN] &&
                    ((relNow[c] > thresh[c][`PTHS_THR1_LSB +: 8]) !=
                     (relPrev[c] > thresh[c][`PTHS_THR1_LSB +: 8]));
            end
        end
    end

    always_comb
    begin
        hottest = 8'hff;
        for (int c = 0; c < NUM_CORES; c++)
            if (relNow[c] < hottest)
                hottest = relNow[c];
    end

    assign anyAct = |coreAtAct;
    assign anyTrip = |coreTrip;

    // Averaging keeps sampling through idle states so the link stays pollable
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            sampleCnt <= '0;
        else if (ce)
            sampleCnt <= (sampleCnt == SAMPLE_LAST) ? '0 : sampleCnt + 1'b1;
    end

    assign avgLink.sampleStb = sampleCnt == SAMPLE_LAST;
    assign avgLink.sampleVal = hottest;

    pths_avg i_pths_avg (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .link(avgLink.avg)
    );

    // Drive on activation whatever the monitor enable; deep idle drops it, wake resumes it
    assign next_drive = anyAct && !pkgDeepIdle && !ctrl[`PTHS_CTRL_INONLY];

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            packageHotPinOe <= 1'b0;
            packageHotPinOut_n <= 1'b1;
        end
        else if (ce)
        begin
            packageHotPinOe <= next_drive;
            packageHotPinOut_n <= !next_drive;
        end
    end

    // Our own drive is masked out until it has left the synchroniser
    assign extHotNow = !hotSyncB && !packageHotPinOe && !oeD1 && !oeD2;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hotSyncA <= 1'b1;
            hotSyncB <= 1'b1;
            oeD1 <= 1'b0;
            oeD2 <= 1'b0;
            extHot <= 1'b0;
            hotEdgeIrq <= 1'b0;
        end
        else if (ce)
        begin
            hotSyncA <= packageHotPinIn_n;
            hotSyncB <= hotSyncA;
            oeD1 <= packageHotPinOe;
            oeD2 <= oeD1;
            extHot <= extHotNow;
            hotEdgeIrq <= ctrl[`PTHS_CTRL_EDGEIRQ] && (extHotNow != extHot);
        end
    end

    // External hot jumps straight to the floor; the internal path steps once per
    // interval to avoid droop from a sudden load change
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            perfState <= PTHS_NORMAL;
            perfLevel <= MAX_PERF;
            stepCnt <= '0;
            clkModEn <= 1'b0;
        end
        else if (ce)
        begin
            stepCnt <= (stepCnt == STEP_LAST) ? '0 : stepCnt + 1'b1;
            if (tripped)
                perfLevel <= 4'h0;
            unique case (perfState)
                PTHS_TRIPPED:
                    clkModEn <= 1'b0;
                PTHS_EXT_LOW:
                begin
                    perfLevel <= 4'h0;
                    clkModEn <= 1'b0;
                    if (tripped)
                        perfState <= PTHS_TRIPPED;
                    else if (!extHot)
                        perfState <= PTHS_NORMAL;
                end
                PTHS_NORMAL, PTHS_STEP_DOWN:
                begin
                    if (tripped)
                        perfState <= PTHS_TRIPPED;
                    else if (extHot)
                    begin
                        perfState <= PTHS_EXT_LOW;
                        perfLevel <= 4'h0;
                        clkModEn <= 1'b0;
                    end
                    else if (anyAct)
                    begin
                        perfState <= PTHS_STEP_DOWN;
                        if (stepCnt == STEP_LAST)
                        begin
                            if (perfLevel != 4'h0)
                                perfLevel <= perfLevel - 1'b1;
                            else
                                clkModEn <= 1'b1;
                        end
                    end
                    else
                    begin
                        perfState <= PTHS_NORMAL;
                        clkModEn <= 1'b0;
                        if (stepCnt == STEP_LAST && perfLevel != MAX_PERF)
                            perfLevel <= perfLevel + 1'b1;
                    end
                end
            endcase
        end
    end

    // Trip latches until reset; nothing software writes can clear it
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tripped <= 1'b0;
            catastrophicTripOut_n <= 1'b1;
            shutdownReq <= 1'b0;
            thermCtlActive <= 1'b0;
        end
        else if (ce)
        begin
            tripped <= tripped || anyTrip;
            catastrophicTripOut_n <= !(tripped || anyTrip);
            shutdownReq <= tripped || anyTrip;
            thermCtlActive <= anyAct;
        end
    end

    // AXI write channels may arrive in either order
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ <= 32'h0000_0000;
            wStrbQ <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OK;
        end
        else if (ce)
        begin
            if (awvalid && awready)
            begin
                awAddrQ <= awaddr;
                awHeld <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready)
            begin
                wDataQ <= wdata;
                wStrbQ <= wstrb;
                wHeld <= 1'b1;
                wready <= 1'b0;
            end
            if (writeFire)
            begin
                bvalid <= 1'b1;
                bresp <= (awAddrQ == `PTHS_REF_OFF || awAddrQ == `PTHS_CTRL_OFF ||
                          awAddrQ == `PTHS_STATUS_OFF ||
                          coreSlot(awAddrQ, `PTHS_THRESH_BASE) < NUM_CORES) ? RESP_OK : RESP_ERR;
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Software-writable configuration
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            actOffset <= '0;
            ctrl <= `PTHS_CTRL_RESET;
            for (int c = 0; c < NUM_CORES; c++)
                thresh[c] <= `PTHS_THRESH_RESET;
        end
        else if (ce && writeFire)
        begin
            if (awAddrQ == `PTHS_REF_OFF && wStrbQ[3])
                actOffset <= wDataQ[`PTHS_REF_OFS_LSB +: `PTHS_REF_OFS_W];
            if (awAddrQ == `PTHS_CTRL_OFF)
                ctrl <= mergeStrb(ctrl, wDataQ, wStrbQ) & `PTHS_CTRL_MASK;
            for (int c = 0; c < NUM_CORES; c++)
                if (coreSlot(awAddrQ, `PTHS_THRESH_BASE) == c)
                    thresh[c] <= mergeStrb(thresh[c], wDataQ, wStrbQ) & `PTHS_THRESH_MASK;
        end
    end

    // Sticky edge flags, write one to clear; a new edge in the clear cycle wins
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            extAssertSeen <= 1'b0;
            extReleaseSeen <= 1'b0;
        end
        else if (ce)
        begin
            if (extHotNow && !extHot)
                extAssertSeen <= 1'b1;
            else if (writeFire && awAddrQ == `PTHS_STATUS_OFF && wStrbQ[0] &&
                     wDataQ[`PTHS_ST_EXT_ASSERT])
                extAssertSeen <= 1'b0;
            if (!extHotNow && extHot)
                extReleaseSeen <= 1'b1;
            else if (writeFire && awAddrQ == `PTHS_STATUS_OFF && wStrbQ[0] &&
                     wDataQ[`PTHS_ST_EXT_RELEASE])
                extReleaseSeen <= 1'b0;
        end
    end

    // Read channel answers one cycle after the address is taken
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OK;
        end
        else if (ce)
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rresp <= RESP_OK;
                rdata <= 32'h0000_0000;
                if (araddr == `PTHS_REF_OFF)
                begin
                    rdata[`PTHS_REF_MAX_LSB +: 8] <= MAX_TEMP;
                    rdata[`PTHS_REF_OFS_LSB +: `PTHS_REF_OFS_W] <= actOffset;
                end
                else if (araddr == `PTHS_CTRL_OFF)
                    rdata <= ctrl;
                else if (araddr == `PTHS_STATUS_OFF)
                    rdata[6:0] <= {clkModEn, extReleaseSeen, extAssertSeen, tripped,
                                   extHot, packageHotPinOe, anyAct};
                else if (araddr == `PTHS_LINK_TEMP_OFF)
                    rdata[7:0] <= avgLink.avgVal;
                else if (araddr == `PTHS_PERF_OFF)
                    rdata[5:0] <= {perfState, perfLevel};
                else if (coreSlot(araddr, `PTHS_CORE_TEMP_BASE) < NUM_CORES)
                    rdata[7:0] <= relNow[coreSlot(araddr, `PTHS_CORE_TEMP_BASE)];
                else if (coreSlot(araddr, `PTHS_THRESH_BASE) < NUM_CORES)
                    rdata <= thresh[coreSlot(araddr, `PTHS_THRESH_BASE)];
                else
                    rresp <= RESP_ERR;
            end
            else if (rvalid && rready)
            begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule

// >>> hdl/pths_regs.svh
// Register map, field positions, reset values and timing counts
// Assumes a 40 MHz mclk and a 32-bit AXI4-Lite register bus
// Operation
// - Each core reading is distance below max junction temperature, saturating at zero.
// - Core temperature register returns that core's instantaneous reading.
// - Link temperature is the hottest reading averaged over a sliding 256 ms.
// - Reading at zero, or within programmed offset, activates thermal control.
// - Activation lowers frequency and voltage of compute and graphics cores.
// - Two programmable thresholds per core raise interrupts when crossed.
// - One package hot output asserts whenever any core reaches activation.
// - Hot output policy ignores whether adaptive thermal monitoring is enabled.
// - Hot pin is bidirectional after reset, configurable as input only.
// - External hot assertion forces lowest performance state, no clock modulation.
// - Lowest state is held until the external party releases the pin.
// - Optional interrupt on each assertion and deassertion edge of hot pin.
// - External assertion is not seen while the device drives the pin.
// - Response to external hot assertion completes under 100 us.
// - Internal power reduction proceeds in small steps over milliseconds.
// - Hot output drops in deep idle and reasserts on wake if hot.
// - Platform link temperature averaging keeps running in every idle state.
// - Damage temperature shuts the package down and asserts the trip output.
// - Reference register holds maximum in 23:16 and activation offset in 29:24.
`ifndef PTHS_REGS_SVH
`define PTHS_REGS_SVH

`define PTHS_CLK_NS 25
`define PTHS_AVG_WINDOW_MS 256
`define PTHS_AVG_DEPTH 16
`define PTHS_AVG_SAMPLE_CYC ((`PTHS_AVG_WINDOW_MS * 1000000 / `PTHS_AVG_DEPTH) / `PTHS_CLK_NS)
`define PTHS_STEP_US 1000
`define PTHS_STEP_CYC (`PTHS_STEP_US * 1000 / `PTHS_CLK_NS)
`define PTHS_HOT_RESP_US 100
`define PTHS_HOT_RESP_CYC (`PTHS_HOT_RESP_US * 1000 / `PTHS_CLK_NS)
`define PTHS_HOT_PIPE_CYC 4
`define PTHS_CNT_W 24

`define PTHS_REF_OFF 8'h00
`define PTHS_CTRL_OFF 8'h04
`define PTHS_STATUS_OFF 8'h08
`define PTHS_LINK_TEMP_OFF 8'h0c
`define PTHS_PERF_OFF 8'h10
`define PTHS_CORE_TEMP_BASE 8'h20
`define PTHS_THRESH_BASE 8'h40

`define PTHS_REF_MAX_LSB 16
`define PTHS_REF_OFS_LSB 24
`define PTHS_REF_OFS_W 6
`define PTHS_CTRL_INONLY 0
`define PTHS_CTRL_EDGEIRQ 1
`define PTHS_CTRL_RESET 32'h0000_0000
`define PTHS_CTRL_MASK 32'h0000_0003
`define PTHS_ST_EXT_ASSERT 4
`define PTHS_ST_EXT_RELEASE 5
`define PTHS_THR0_LSB 0
`define PTHS_THR1_LSB 8
`define PTHS_THR0_EN 16
`define PTHS_THR1_EN 17
`define PTHS_THRESH_MASK 32'h0003_ffff
`define PTHS_THRESH_RESET 32'h0000_0000
`define PTHS_MAX_TEMP_DEF 8'h64
`define PTHS_TRIP_MARGIN_DEF 8'h19

`endif

// >>> hdl/pths_pkg.sv
// Types shared by the thermal alarm block and its averaging unit
// Assumes the constants of pths_regs.svh
`include "pths_regs.svh"
package pths_pkg;
    typedef logic [7:0] pths_temp_t;
    typedef logic [31:0] pths_word_t;
    typedef enum logic [1:0] {PTHS_NORMAL, PTHS_STEP_DOWN, PTHS_EXT_LOW, PTHS_TRIPPED} pths_perf_t;
    typedef logic [`PTHS_CNT_W-1:0] pths_cnt_t;
endpackage

// >>> hdl/pths_avg_if.sv
// Link between the alarm logic and the sliding-window averager
// Assumes both ends run on mclk
`timescale 1ns/1ps
interface pths_avg_if;
    logic sampleStb;
    pths_pkg::pths_temp_t sampleVal;
    pths_pkg::pths_temp_t avgVal;
    modport feed (output sampleStb, output sampleVal, input avgVal);
    modport avg (input sampleStb, input sampleVal, output avgVal);
endinterface

// >>> hdl/pths_avg.sv
// Sliding-window average of the hottest package reading
// Assumes one sample strobe per window slot from the alarm logic
`timescale 1ns/1ps
`include "pths_regs.svh"
module pths_avg #(
    parameter int DEPTH = `PTHS_AVG_DEPTH
) (
    // Clocking
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Samples in, average out
    pths_avg_if.avg link
);
    import pths_pkg::*;
    localparam int LG = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << LG) != DEPTH)
        $error("DEPTH must be a power of two, at least 2");

    pths_temp_t ring [DEPTH];
    logic [LG-1:0] slot;
    logic [LG+7:0] sum;
    logic [LG+7:0] next_sum;

    assign next_sum = sum + {{LG{1'b0}}, link.sampleVal} - {{LG{1'b0}}, ring[slot]};

    // Empty slots start at zero, so the first window reads hot until filled
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
                ring[i] <= 8'h00;
            slot <= '0;
            sum <= '0;
            link.avgVal <= 8'h00;
        end
        else if (ce && link.sampleStb)
        begin
            ring[slot] <= link.sampleVal;
            slot <= slot + 1'b1;
            sum <= next_sum;
            link.avgVal <= next_sum[LG+7:LG];
        end
    end
endmodule

// >>> tb/pths_props.sv
// Pin-level checks for the thermal alarm block
// Assumes a bind into pths_top; one clock, async reset
`timescale 1ns/1ps
module pths_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bus handshakes
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic bvalid,
    input wire logic bready,
    // Pins and levels
    input wire logic pkgDeepIdle,
    input wire logic packageHotPinIn_n,
    input wire logic packageHotPinOut_n,
    input wire logic packageHotPinOe,
    input wire logic [3:0] perfLevel,
    input wire logic clkModEn,
    input wire logic hotEdgeIrq,
    input wire logic catastrophicTripOut_n,
    input wire logic shutdownReq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    property p_ext_low;
        (!packageHotPinIn_n && !packageHotPinOe)[*6] |-> perfLevel == 4'h0 && !clkModEn;
    endproperty
    a_ext_low: assert property (p_ext_low) else $error("ext hot not lowest");
    // Four cycles let the synchroniser see the pin, so internal stepping cannot interfere
    property p_ext_hold;
        (perfLevel == 4'h0 && !packageHotPinIn_n && !packageHotPinOe)[*4] |=> perfLevel == 4'h0;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("lowest level left");
    property p_pin_pair;
        packageHotPinOe != packageHotPinOut_n;
    endproperty
    a_pin_pair: assert property (p_pin_pair) else $error("hot pin drive split");
    property p_trip;
        !catastrophicTripOut_n |=> !catastrophicTripOut_n && shutdownReq && perfLevel == 4'h0;
    endproperty
    a_trip: assert property (p_trip) else $error("trip not held");
    property p_irq_pulse;
        hotEdgeIrq |=> !hotEdgeIrq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("edge irq too long");
    property p_idle;
        pkgDeepIdle |=> !packageHotPinOe;
    endproperty
    a_idle: assert property (p_idle) else $error("hot out driven in idle");
    property p_rd;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_bhold;
        bvalid && !bready |=> bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
endmodule

// >>> tb/pths_plat.sv
// Platform monitor pulling the shared hot pin low on request
// Assumes the bench forms the wired-low level from all enables
`timescale 1ns/1ps
module pths_plat (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Overheat request and pull
    input wire logic assertReq,
    output logic extPull
);
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n) extPull <= 1'b0;
        else extPull <= assertReq;
    end
endmodule

// >>> tb/test_pths_top.sv
// Self-checking bench for the thermal alarm block
// Assumes design files, pths_props and pths_plat compile first
`timescale 1ns/1ps
module test_pths_top;
    import pths_pkg::*;
    logic mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, pkgDeepIdle, hotReq, extPull;
    logic awready, wready, bvalid, arready, rvalid, clkModEn, thermCtlActive, hotEdgeIrq;
    logic packageHotPinOut_n, packageHotPinOe, catastrophicTripOut_n, shutdownReq;
    logic [7:0] awaddr, araddr, coreTempSensor;
    logic [3:0] wstrb, perfLevel;
    logic [1:0] bresp, rresp, rs, threshIrq;
    pths_word_t wdata, rdata, d;
    wire logic hotWire_n = !(packageHotPinOe || extPull);
    int num_errors = 0, cmp_count = 0;
    int edgeIrqs = 0, threshIrqs = 0;
    pths_top #(.NUM_CORES(1), .SAMPLE_CYC(4), .STEP_CYC(4)) i_pths_top (
        .mclk, .rst_n, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .coreTempSensor, .pkgDeepIdle, .packageHotPinIn_n(hotWire_n), .packageHotPinOut_n,
        .packageHotPinOe, .perfLevel, .clkModEn, .thermCtlActive, .coreThreshIrq(threshIrq),
        .hotEdgeIrq, .catastrophicTripOut_n, .shutdownReq);
    pths_plat i_pths_plat (.mclk, .rst_n, .assertReq(hotReq), .extPull);
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) if (hotEdgeIrq === 1'b1) edgeIrqs++;
    always @(posedge mclk) if (threshIrq === 2'b01) threshIrqs++;
    task automatic close_out;
        if (num_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic guard(input int n);
        if (n >= 60)
        begin
            num_errors++;
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input pths_word_t v);
        int n;
        n = 0;
        @(posedge mclk);
        {awaddr, wdata, wstrb} <= {a, v, 4'hf};
        {awvalid, wvalid, bready} <= 3'b111;
        do
        begin
            @(posedge mclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 60);
        rs = bresp;
        bready <= 1'b0;
        guard(n);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge mclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do
        begin
            @(posedge mclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 60);
        {d, rs} = {rdata, rresp};
        rready <= 1'b0;
        guard(n);
    endtask
    task automatic set_temp(input logic [7:0] t, input logic req);
        @(posedge mclk);
        {coreTempSensor, hotReq} <= {t, req};
    endtask
    task automatic t_sense;
        chk(32'(perfLevel), 32'hf);
        rd(8'h04);
        chk(d, 32'h0);
        rd(8'h00);
        chk(32'(d[23:16]), 32'h64);
        rd(8'h20);
        chk(d, 32'h24);
        wr(8'h40, 32'h0001_0010);
        set_temp(8'h5a, 1'b0);
        cyc(4);
        chk(32'(threshIrqs), 32'h1);
        wr(8'h00, 32'h0200_0000);
        set_temp(8'h62, 1'b0);
        cyc(4);
        chk(32'({thermCtlActive, packageHotPinOe, packageHotPinOut_n}), 32'h6);
        @(posedge mclk);
        pkgDeepIdle <= 1'b1;
        cyc(2);
        chk(32'(packageHotPinOe), 32'h0);
        @(posedge mclk);
        pkgDeepIdle <= 1'b0;
        cyc(2);
        chk(32'(packageHotPinOe), 32'h1);
    endtask
    task automatic t_bidir;
        set_temp(8'h70, 1'b1);
        cyc(4);
        rd(8'h20);
        chk(d, 32'h0);
        rd(8'h08);
        chk(32'(d[2]), 32'h0);
        chk(32'(perfLevel inside {[4'h1:4'he]}), 32'h1);
        set_temp(8'h40, 1'b1);
        cyc(12);
        chk(32'(perfLevel), 32'h0);
        set_temp(8'h40, 1'b0);
        cyc(14);
        chk(32'(perfLevel != 4'h0), 32'h1);
    endtask
    task automatic t_ext;
        chk(32'(edgeIrqs), 32'h0);
        wr(8'h08, 32'h30);
        wr(8'h04, 32'h3);
        set_temp(8'h70, 1'b0);
        cyc(4);
        chk(32'({packageHotPinOe, thermCtlActive}), 32'h1);
        set_temp(8'h70, 1'b1);
        cyc(6);
        chk(32'({perfLevel, clkModEn}), 32'h0);
        cyc(40);
        chk(32'(perfLevel), 32'h0);
        set_temp(8'h40, 1'b0);
        cyc(8);
        chk(32'(edgeIrqs), 32'h2);
        rd(8'h08);
        chk(32'(d[5:4]), 32'h3);
        wr(8'h04, 32'h0);
    endtask
    task automatic t_bad;
        rd(8'h80);
        chk({d[29:0], rs}, 32'h2);
        wr(8'h0c, 32'h5a);
        chk(32'(rs), 32'h2);
    endtask
    task automatic t_trip;
        set_temp(8'h7d, 1'b0);
        cyc(4);
        chk(32'({catastrophicTripOut_n, shutdownReq, perfLevel}), 32'h10);
        set_temp(8'h40, 1'b0);
        cyc(4);
        chk(32'(catastrophicTripOut_n), 32'h0);
    endtask
    initial
    begin
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, pkgDeepIdle, hotReq} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        coreTempSensor = 8'h40;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        cyc(1);
        t_sense();
        t_bidir();
        t_ext();
        t_bad();
        t_trip();
        close_out();
    end
endmodule
bind pths_top pths_props i_pths_props (.mclk, .rst_n, .arvalid, .arready, .rvalid, .bvalid,
    .bready, .pkgDeepIdle, .packageHotPinIn_n, .packageHotPinOut_n, .packageHotPinOe,
    .perfLevel, .clkModEn, .hotEdgeIrq, .catastrophicTripOut_n, .shutdownReq);
